/* spf_cfg.svh */
// Purpose: constants for the self-programming flash controller
// Assumes: one cpu clock, synchronous active-high reset
// Notes:   timing windows are in cpu cycles
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH
`define SPF_CMD_W          5
`define SPF_CMD_PGWRITE    5'h05
`define SPF_CMD_PGERASE    5'h03
`define SPF_CMD_BUFFILL    5'h01
`define SPF_CMD_LOCKWR     5'h09
`define SPF_CMD_APPREEN    5'h11
`define SPF_CMD_READBACK   5'h09
`define SPF_BIT_GO         0
`define SPF_BIT_LOCKSEL    3
`define SPF_BIT_READEN     4
`define SPF_BIT_APPBUSY    6
`define SPF_SPM_WINDOW     3'h4
`define SPF_LOAD_WINDOW    3'h5
`define SPF_PTR_FUSE_LO    16'h0000
`define SPF_PTR_LOCK       16'h0001
`define SPF_PTR_FUSE_HI    16'h0003
`define SPF_PROG_CYCLES    8'h20
`define SPF_LOCK_RESET     6'h3f
`endif

/* spf_pkg.sv */
// Purpose: types shared by both ends of the self-programming link
// Assumes: spf_cfg.svh holds the numeric constants
// Notes:   types only
package spf_pkg;
	typedef enum logic [1:0] {SPF_IDLE, SPF_ARMED, SPF_BUSY} spf_state_e;
	typedef enum logic [1:0] {SPF_OP_NONE, SPF_OP_STORE, SPF_OP_LOAD}
		spf_op_e;
	typedef logic [15:0] spf_ptr_t;
endpackage

/* spf_if.sv */
// Purpose: link between processor core and the flash self-program block
// Assumes: one clock, ops are one-cycle pulses
// Notes:   stall is combinational from the device
`timescale 1ns/1ps
interface spf_if;
	logic        ctl_wr;
	logic [7:0]  ctl_wdata;
	logic [7:0]  ctl_rdata;
	logic        store_op;
	logic        load_op;
	logic [15:0] ptr;
	logic [15:0] data_word;
	logic [7:0]  load_data;
	logic        load_special;
	logic        stall;
	modport dev (input ctl_wr, ctl_wdata, store_op, load_op, ptr, data_word,
		output ctl_rdata, load_data, load_special, stall);
	modport cpu (output ctl_wr, ctl_wdata, store_op, load_op, ptr, data_word,
		input ctl_rdata, load_data, load_special, stall);
endinterface

/* spf_cpu_end.sv */
// Purpose: core-side sequencer issuing control writes and program ops
// Assumes: user requests are one-cycle pulses while ready is high
// Notes:   the store follows the control write in the next cycle
`timescale 1ns/1ps
module spf_cpu_end
	import spf_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	spf_if.cpu               link,
	input  wire logic        req,
	input  wire logic [4:0]  req_cmd,
	input  wire logic        req_load,
	input  wire logic [15:0] req_ptr,
	input  wire logic [15:0] req_data,
	output logic             ready,
	output logic             done,
	output logic [7:0]       result,
	output logic             result_special
);
`include "spf_cfg.svh"
	spf_state_e state_reg;
	logic       is_load_reg;
	logic [4:0] cmd_reg;
	logic [15:0] ptr_reg;
	logic [15:0] data_reg;
	logic       wr_reg;
	logic       op_reg;
	logic       poll_reg;
	logic       load_seen_reg;
	// page write keeps the in-page word bits at zero
	wire [15:0] ptr_fix = (req_cmd == `SPF_CMD_PGWRITE) ?
		{req_ptr[15:7], 7'h00} : req_ptr;
	wire        go_clear = ~link.ctl_rdata[`SPF_BIT_GO];
	// no other access, and so no interrupt fetch, while a request runs
	assign ready = (state_reg == SPF_IDLE);
	assign link.ctl_wr    = wr_reg;
	assign link.ctl_wdata = {3'h0, cmd_reg};
	assign link.store_op  = op_reg & ~is_load_reg;
	assign link.load_op   = op_reg & is_load_reg;
	assign link.ptr       = ptr_reg;
	assign link.data_word = data_reg;
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= SPF_IDLE;
			is_load_reg <= 1'b0;
			cmd_reg <= 5'h00;
			ptr_reg <= 16'h0000;
			data_reg <= 16'h0000;
			wr_reg <= 1'b0;
			op_reg <= 1'b0;
			poll_reg <= 1'b0;
			load_seen_reg <= 1'b0;
			done <= 1'b0;
			result <= 8'h00;
			result_special <= 1'b0;
		end else begin
			wr_reg <= 1'b0;
			op_reg <= 1'b0;
			done <= 1'b0;
			load_seen_reg <= link.load_op;
			case (state_reg)
				SPF_IDLE: if (req) begin
					cmd_reg <= req_cmd;
					is_load_reg <= req_load;
					ptr_reg <= ptr_fix;
					data_reg <= req_data;
					wr_reg <= ~(req_load & req_cmd == 5'h00);
					state_reg <= SPF_ARMED;
				end
				SPF_ARMED: if (~link.stall) begin
					// op issued one cycle after the write: inside the window
					op_reg <= 1'b1;
					poll_reg <= 1'b0;
					state_reg <= SPF_BUSY;
				end
				SPF_BUSY: if (~link.stall) begin
					poll_reg <= 1'b1;
					// load data stands from the cycle after the load
					if (is_load_reg & load_seen_reg) begin
						result <= link.load_data;
						result_special <= link.load_special;
					end
					// wait for go to read clear before the next request
					if (poll_reg & go_clear) begin
						done <= 1'b1;
						state_reg <= SPF_IDLE;
					end
				end
				default: state_reg <= SPF_IDLE;
			endcase
		end
	end
endmodule

/* spf_dev_end.sv */
// Purpose: flash self-programming control register, arming windows and
//          fuse / lock readback
// Assumes: the core issues store/load ops as one-cycle pulses
// Notes:   flash array itself lives outside; wr_* pulses drive it
//
// How it works
// - page write armed by 00101, store within four
// - page address in pointer 14:7, low zero
// - page write ignores the data word registers
// - stall core during write, erase, lock write
// - go bit stays set until programming ends
// - core follows programming store with ones, nop; the core end issues neither and just waits out the stall
// - 10001 plus store clears app busy bit
// - app busy and read enable are inert
// - pointer 0001 readback returns lock bits
// - lock select and go auto-clear on expiry
// - disarmed load does an ordinary constant read
// - pointer 0000 returns low fuses
// - pointer 0003 returns high fuses
// - programmed reads zero, unprogrammed reads one
// - two independent boot lock pairs
// - boot lock 11 unprogrammed allows boot rewrite
// - keep interrupts off during page write
// - no application access while erasing or writing
// - pointer 15 ignored, page and word fields
// - eeprom write blocks programming and readback
`timescale 1ns/1ps
module spf_dev_end
	import spf_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	spf_if.dev               link,
	input  wire logic        eeprom_busy,
	input  wire logic [5:0]  fuse_low_n,
	input  wire logic [6:0]  fuse_high_n,
	input  wire logic [7:0]  flash_const,
	output logic             wr_page,
	output logic             wr_erase,
	output logic             wr_buffer,
	output logic [7:0]       wr_page_sel,
	output logic [5:0]       wr_word_sel,
	output logic [15:0]      wr_data,
	output logic [5:0]       lock_bits,
	output logic             prog_busy
);
`include "spf_cfg.svh"
	spf_state_e  state_reg;
	spf_state_e  state_next;
	logic [4:0]  cmd_reg;
	logic [4:0]  cmd_next;
	logic [2:0]  win_reg;
	logic [2:0]  win_next;
	logic [7:0]  busy_cnt_reg;
	logic [7:0]  busy_cnt_next;
	logic        app_busy_reg;
	logic        app_busy_next;
	logic [5:0]  lock_next;
	logic [7:0]  load_next;

	// cycles left for the matching op once a command is armed
	function automatic logic [2:0] win_len(input logic [4:0] c);
		win_len = (c == `SPF_CMD_READBACK) ? `SPF_LOAD_WINDOW :
			`SPF_SPM_WINDOW;
	endfunction

	// commands whose store halts the core until the array is done
	function automatic logic is_timed(input logic [4:0] c);
		is_timed = (c == `SPF_CMD_PGWRITE) | (c == `SPF_CMD_PGERASE) |
			(c == `SPF_CMD_LOCKWR);
	endfunction

	// lowest window count at which a store still counts: the readback
	// code shares its window with the lock write, and a store gets one
	// cycle less than a load
	function automatic logic [2:0] st_floor(input logic [4:0] c);
		st_floor = (c == `SPF_CMD_READBACK) ? 3'h2 : 3'h1;
	endfunction

	wire idle  = (state_reg == SPF_IDLE);
	wire armed = (state_reg == SPF_ARMED);
	wire busy  = (state_reg == SPF_BUSY);
	wire act   = armed | busy;
	// eeprom write blocks any new arming
	wire arm = idle & link.ctl_wr & link.ctl_wdata[`SPF_BIT_GO] &
		~eeprom_busy;
	// ops count only while their window is open
	wire is_rb = armed & (win_reg != 3'h0) & link.load_op &
		(cmd_reg == `SPF_CMD_READBACK);
	wire is_st = armed & (win_reg >= st_floor(cmd_reg)) & link.store_op;
	wire st_take = is_st & ~eeprom_busy;
	wire timed_take = st_take & is_timed(cmd_reg);
	// last open cycle went by with no op, or eeprom got busy
	wire expire = armed & ~is_rb & ~st_take &
		((win_reg <= 3'h1) | eeprom_busy);
	wire busy_end = busy & (busy_cnt_reg == 8'h01);
	wire fill_take = st_take & (cmd_reg == `SPF_CMD_BUFFILL);
	wire lock_take = st_take & (cmd_reg == `SPF_CMD_LOCKWR);
	wire reen_take = st_take & (cmd_reg == `SPF_CMD_APPREEN);
	// page write leaves the data word out of the path
	wire [15:0] wdata_sel = (cmd_reg == `SPF_CMD_PGWRITE) ? 16'h0000 :
		link.data_word;

	// fuse levels are fixed after power-up, so no synchroniser is needed;
	// a programmed cell reads 0, unused positions read 1
	wire [7:0] fuse_lo = {fuse_low_n[5:4], 2'h3, fuse_low_n[3:0]};
	wire [7:0] fuse_hi = {fuse_high_n[6:4], 1'b1, fuse_high_n[3:0]};
	// bit 15 takes no part in any decode
	wire [15:0] ptr_eff = {1'b0, link.ptr[14:0]};
	wire [7:0] rb_sel =
		(ptr_eff == `SPF_PTR_LOCK)    ? {2'h3, lock_bits} :
		(ptr_eff == `SPF_PTR_FUSE_LO) ? fuse_lo :
		(ptr_eff == `SPF_PTR_FUSE_HI) ? fuse_hi : 8'hff;
	wire rb_ok = is_rb & ~eeprom_busy;
	// disarmed load reads plain program memory
	assign load_next = rb_ok ? rb_sel : flash_const;

	assign win_next = arm ? win_len(link.ctl_wdata[4:0]) :
		armed ? win_reg - 3'h1 : win_reg;
	assign busy_cnt_next = timed_take ? `SPF_PROG_CYCLES :
		busy ? busy_cnt_reg - 8'h01 : busy_cnt_reg;
	// app busy is set by a timed store and cleared by the re-enable
	// store; it gates nothing here and is kept for software
	assign app_busy_next = timed_take ? 1'b1 :
		reen_take ? 1'b0 : app_busy_reg;
	// only the two boot lock pairs move, each from its own field
	assign lock_next = lock_take ?
		lock_bits & {link.data_word[5:2], 2'h3} : lock_bits;

	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		case (state_reg)
			SPF_IDLE: begin
				if (arm) begin
					state_next = SPF_ARMED;
					cmd_next = link.ctl_wdata[4:0];
				end
			end
			SPF_ARMED: begin
				if (timed_take) begin
					state_next = SPF_BUSY;
				end else if (is_rb | st_take | expire) begin
					// readback done, untimed store taken or window lapsed: disarm
					state_next = SPF_IDLE;
					cmd_next = 5'h00;
				end
			end
			SPF_BUSY: begin
				if (busy_end) begin
					state_next = SPF_IDLE;
					cmd_next = 5'h00;
				end
			end
			default: begin
				state_next = SPF_IDLE;
				cmd_next = 5'h00;
			end
		endcase
	end

	// core halts for the whole timed operation
	assign link.stall = busy;
	assign prog_busy = busy;
	// go stays visible until the operation ends
	assign link.ctl_rdata = {1'b0, app_busy_reg, 1'b0, cmd_reg[4] & act,
		cmd_reg[3] & act, cmd_reg[2:1] & {2{act}}, act};

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= SPF_IDLE;
			cmd_reg <= 5'h00;
			win_reg <= 3'h0;
			busy_cnt_reg <= 8'h00;
			app_busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			win_reg <= win_next;
			busy_cnt_reg <= busy_cnt_next;
			app_busy_reg <= app_busy_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_bits <= `SPF_LOCK_RESET;
		end else begin
			lock_bits <= lock_next;
		end
	end

	// load result stands until the next load; the flag is one pulse
	always_ff @(posedge mclk) begin
		if (rst) begin
			link.load_data <= 8'h00;
			link.load_special <= 1'b0;
		end else begin
			link.load_special <= rb_ok;
			if (link.load_op) begin
				link.load_data <= load_next;
			end
		end
	end

	// array strobes; a lapsed window reaches none of them
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_page <= 1'b0;
			wr_erase <= 1'b0;
			wr_buffer <= 1'b0;
			wr_page_sel <= 8'h00;
			wr_word_sel <= 6'h00;
			wr_data <= 16'h0000;
		end else begin
			wr_page <= busy_end & (cmd_reg == `SPF_CMD_PGWRITE);
			wr_erase <= busy_end & (cmd_reg == `SPF_CMD_PGERASE);
			wr_buffer <= fill_take;
			if (st_take) begin
				wr_page_sel <= link.ptr[14:7];
				wr_word_sel <= link.ptr[6:1];
				wr_data <= wdata_sel;
			end
		end
	end
endmodule

/* spf_link_monitor.sv */
// Purpose: concurrent checks on the core to flash-control link
// Assumes: one clock, synchronous active-high reset
// Notes:   eeprom_busy is not on the link, so refusals are judged in tb
`timescale 1ns/1ps
`include "spf_cfg.svh"
module spf_link_monitor (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic [7:0] ctl_rdata,
	input wire logic       store_op,
	input wire logic       load_op,
	input wire logic       load_special,
	input wire logic       stall
);
	logic [7:0] stall_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// counts the length of each stall so its fall can be judged
	always_ff @(posedge mclk) begin
		if (rst || !stall)
			stall_cnt <= 8'h00;
		else
			stall_cnt <= stall_cnt + 8'h01;
	end
	chk_special_cause: assert property (load_special |-> $past(load_op))
		else $error("special result without a load");
	chk_stall_length: assert property
		($fell(stall) |-> stall_cnt == `SPF_PROG_CYCLES)
		else $error("stall length wrong");
	chk_timed_stalls: assert property
		(store_op && ctl_rdata[0] && (ctl_rdata[1] || ctl_rdata[2]) |=> stall)
		else $error("timed store did not stall");
	chk_go_busy: assert property (stall |-> ctl_rdata[0])
		else $error("go clear while busy");
	chk_go_clears: assert property
		($fell(stall) |-> ##[0:2] !ctl_rdata[0])
		else $error("go stuck after programming");
	chk_arm_expiry: assert property
		((ctl_wr && ctl_wdata[4:0] == 5'h09 && !stall) ##1
		(!load_op && !store_op)[*5] |=> !ctl_rdata[0])
		else $error("armed window did not expire");
	chk_readback_done: assert property
		(load_special |-> !ctl_rdata[3] && !ctl_rdata[0])
		else $error("readback left arming set");
	chk_plain_load: assert property
		(load_op && !ctl_rdata[0] |=> !load_special)
		else $error("disarmed load gave readback");
	chk_app_reenable: assert property
		(store_op && ctl_rdata[0] && ctl_rdata[4] |-> ##[1:3] !ctl_rdata[6])
		else $error("app busy not cleared");
endmodule

/* tb.sv */
// Purpose: self-checking bench driving both ends through their user ports
// Assumes: fuse inputs are active low, lock bits reset to all ones
// Notes:   sequence is one request task plus byte and bit compares
`timescale 1ns/1ps
`include "spf_cfg.svh"
module tb;
	logic        mclk = 1'b0, rst = 1'b1, req = 1'b0, req_load = 1'b0;
	logic        eeprom_busy = 1'b0;
	logic [4:0]  req_cmd = 5'h00;
	logic [15:0] req_ptr = 16'h0000, req_data = 16'h0000;
	logic        ready, done, result_special, wr_page, prog_busy;
	logic [7:0]  result, wr_page_sel, pg_sel, busy_cnt = 8'h00, b0;
	logic [5:0]  lock_bits, wr_word_sel;
	logic        wr_erase, wr_buffer;
	logic [15:0] wr_data;
	logic [7:0]  er_cnt = 8'h00, fill_cnt = 8'h00;
	int          error_cnt = 0, cmp_count = 0, cyc = 0;
	spf_if lk ();
	spf_cpu_end spf_cpu_end_i (.mclk(mclk), .rst(rst), .link(lk), .req(req),
		.req_cmd(req_cmd), .req_load(req_load), .req_ptr(req_ptr),
		.req_data(req_data), .ready(ready), .done(done), .result(result),
		.result_special(result_special));
	spf_dev_end spf_dev_end_i (.mclk(mclk), .rst(rst), .link(lk),
		.eeprom_busy(eeprom_busy), .fuse_low_n(6'h29), .fuse_high_n(7'h34),
		.flash_const(8'h5a), .wr_page(wr_page), .wr_erase(wr_erase),
		.wr_buffer(wr_buffer), .wr_page_sel(wr_page_sel),
		.wr_word_sel(wr_word_sel), .wr_data(wr_data),
		.lock_bits(lock_bits), .prog_busy(prog_busy));
	spf_link_monitor spf_link_monitor_i (.mclk(mclk), .rst(rst),
		.ctl_wr(lk.ctl_wr), .ctl_wdata(lk.ctl_wdata), .ctl_rdata(lk.ctl_rdata),
		.store_op(lk.store_op), .load_op(lk.load_op),
		.load_special(lk.load_special), .stall(lk.stall));
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (wr_page === 1'b1) pg_sel <= wr_page_sel;
		if (prog_busy === 1'b1) busy_cnt <= busy_cnt + 8'h01;
		if (wr_erase === 1'b1) er_cnt <= er_cnt + 8'h01;
		if (wr_buffer === 1'b1) fill_cnt <= fill_cnt + 8'h01;
		cyc++;
		// generous ceiling; the whole sequence needs under two hundred cycles
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] g, e, m);
		cmp_count++;
		if ((g & m) !== (e & m)) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, e);
		chk_byte({7'h00, g}, {7'h00, e}, 8'h01);
	endtask
	task automatic do_req(input logic [4:0] c, input logic ld,
		input logic [15:0] p, d);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		req <= 1'b1;
		req_cmd <= c;
		req_load <= ld;
		req_ptr <= p;
		req_data <= d;
		@(posedge mclk);
		req <= 1'b0;
		n = 0;
		while (n < 300) begin
			@(negedge mclk);
			if (done === 1'b1) break;
			n++;
		end
		chk_bit(n < 300, 1'b1);
		@(posedge mclk);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		do_req(5'h09, 1'b1, 16'h0001, 16'h0000);
		chk_byte(result, 8'h3f, 8'h3f);
		chk_bit(result_special, 1'b1);
		do_req(5'h09, 1'b1, 16'h0000, 16'h0000);
		chk_byte(result, 8'h89, 8'hcf);
		do_req(5'h09, 1'b1, 16'h0003, 16'h0000);
		chk_byte(result, 8'h64, 8'hef);
		do_req(5'h00, 1'b1, 16'h0003, 16'h0000);
		chk_byte(result, 8'h5a, 8'hff);
		chk_bit(result_special, 1'b0);
		eeprom_busy <= 1'b1;
		do_req(5'h09, 1'b1, 16'h0000, 16'h0000);
		chk_bit(result_special, 1'b0);
		eeprom_busy <= 1'b0;
		b0 = busy_cnt;
		do_req(`SPF_CMD_BUFFILL, 1'b0, 16'h0046, 16'hbeef);
		chk_byte(wr_data[15:8], 8'hbe, 8'hff);
		chk_byte(wr_data[7:0], 8'hef, 8'hff);
		chk_byte({2'b00, wr_word_sel}, 8'h23, 8'h3f);
		chk_byte(fill_cnt, 8'h01, 8'hff);
		chk_byte(busy_cnt - b0, 8'h00, 8'hff);
		b0 = busy_cnt;
		do_req(`SPF_CMD_PGWRITE, 1'b0, 16'hc680, 16'h1234);
		chk_byte(pg_sel, 8'h8d, 8'hff);
		chk_byte(busy_cnt - b0, `SPF_PROG_CYCLES, 8'hff);
		chk_byte(wr_data[15:8], 8'h00, 8'hff);
		chk_byte(wr_data[7:0], 8'h00, 8'hff);
		b0 = busy_cnt;
		do_req(`SPF_CMD_PGERASE, 1'b0, 16'h0100, 16'h0000);
		chk_byte(busy_cnt - b0, `SPF_PROG_CYCLES, 8'hff);
		chk_byte(er_cnt, 8'h01, 8'hff);
		b0 = busy_cnt;
		do_req(`SPF_CMD_LOCKWR, 1'b0, 16'h0000, 16'hfff3);
		chk_byte(busy_cnt - b0, `SPF_PROG_CYCLES, 8'hff);
		chk_byte({2'b00, lock_bits}, 8'h33, 8'h3f);
		do_req(5'h09, 1'b1, 16'h8001, 16'h0000);
		chk_byte(result, 8'h33, 8'h3f);
		do_req(`SPF_CMD_APPREEN, 1'b0, 16'h0000, 16'h0000);
		chk_bit(lk.ctl_rdata[6], 1'b0);
		end_of_test();
	end
endmodule
